// [hdl/stepper_motion_pkg.sv]
// constants and types shared by the motion profile unit
package stepper_motion_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] REV_STEP_LO_ADDR = 8'h1c;
   localparam logic [7:0] REV_STEP_HI_ADDR = 8'h1d;
   localparam logic [7:0] FWD_ROT_LO_ADDR  = 8'h1e;
   localparam logic [7:0] FWD_ROT_HI_ADDR  = 8'h1f;
   localparam logic [7:0] REV_ROT_LO_ADDR  = 8'h20;
   localparam logic [7:0] REV_ROT_HI_ADDR  = 8'h21;
   localparam logic [7:0] OVERDRIVE0_ADDR  = 8'h22;
   localparam logic [7:0] OVERDRIVE1_ADDR  = 8'h23;
   localparam logic [7:0] RAMP_CTRL_ADDR   = 8'h24;
   localparam int         REG_COUNT        = 9;
   localparam logic [7:0] REG_RESET        = 8'h00;
   localparam logic [7:0] FULL_WMASK       = 8'hff;
   localparam logic [7:0] RAMP_CTRL_WMASK  = 8'h3f;
   // ==========================================================
   // ramp control fields
   localparam int RAMP_UP_BIT     = 5;
   localparam int RAMP_DOWN_BIT   = 4;
   localparam int RAMP_FACTOR_MSB = 3;
   // ==========================================================
   // timing: 1 us internal tick from the 40 MHz clock
   localparam int CLK_PERIOD_NS   = 25;
   localparam int TICK_PERIOD_NS  = 1000;
   localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
   // smallest width of prescaler range 0 is 3 ticks
   localparam int RANGE_MIN_US    = 3;
   localparam int RANGE_MIN_TICKS = RANGE_MIN_US * 1000 / TICK_PERIOD_NS;
   // every range spans 8192 of its own smallest widths
   localparam int               WIDTH_W         = 14;
   localparam logic [WIDTH_W-1:0] RANGE_MAX_UNITS = 14'h2000;
   // ==========================================================
   // carriers
   typedef struct packed {
      logic [2:0]  prescaler;
      logic [12:0] value;
   } pulse_width_t;

   typedef struct packed {
      logic       hard_stop;
      logic       continuous;
      logic [1:0] mode;
      logic [1:0] dir;
   } motor_control_t;

   typedef struct packed {
      logic       ctrl_en;
      logic [1:0] overdrive_sel;
      logic       unit_rotation;
   } interrupt_setup_t;

   localparam logic [1:0] MODE_ROTATIONS = 2'b01;

   typedef enum {
      RUN_IDLE,
      RUN_ACCEL,
      RUN_CRUISE,
      RUN_OVERDRIVE,
      RUN_DECEL
   } run_state_t;
endpackage

// [hdl/step_period_timer.sv]
// step period timer: one step pulse per programmed width
`timescale 1ns/1ps
module step_period_timer (
   // clock and reset
   input  wire logic                                 mclk_i,
   input  wire logic                                 rst_i,
   // width of the current step
   input  wire logic                                 run_i,
   input  wire logic [2:0]                           prescaler_i,
   input  wire logic [stepper_motion_pkg::WIDTH_W-1:0] units_i,
   // step strobe
   output logic                                      step_o
);
   import stepper_motion_pkg::*;

   logic [5:0]         us_cnt_r;
   logic [8:0]         sub_cnt_r;
   logic [WIDTH_W-1:0] unit_cnt_r;
   logic [8:0]         sub_len_w;
   logic               tick_w;
   logic               sub_last_w;
   logic               unit_last_w;

   // ==========================================================
   // one range-minimum width lasts 3 ticks scaled by the prescaler
   assign sub_len_w   = 9'(RANGE_MIN_TICKS) << prescaler_i;
   assign tick_w      = us_cnt_r == 6'(TICK_CYCLES - 1);
   assign sub_last_w  = sub_cnt_r == sub_len_w - 9'h001;
   assign unit_last_w = (unit_cnt_r + 14'h0001 >= units_i);

   always_ff @(posedge mclk_i) begin
      if (rst_i || !run_i || tick_w) begin
         us_cnt_r <= 6'h00;
      end else begin
         us_cnt_r <= us_cnt_r + 6'h01;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i || !run_i) begin
         sub_cnt_r <= 9'h000;
      end else if (tick_w) begin
         sub_cnt_r <= sub_last_w ? 9'h000 : sub_cnt_r + 9'h001;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i || !run_i) begin
         unit_cnt_r <= 14'h0000;
      end else if (tick_w && sub_last_w) begin
         unit_cnt_r <= unit_last_w ? 14'h0000 : unit_cnt_r + 14'h0001;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         step_o <= 1'b0;
      end else begin
         step_o <= run_i && tick_w && sub_last_w && unit_last_w;
      end
   end
endmodule

// [hdl/stepper_motion_profile.sv]
// motion profile: targets, overdrive counts and step width ramp
//
// Contract
// - reverse step target, two bytes, reset zero
// - forward rotation target, two bytes, reset zero
// - reverse rotation target, two bytes, reset zero
// - two overdrive counts, one per sensor input
// - overdrive count ignored when feature disabled
// - overdrive keeps turning, same direction
// - zero overdrive count adds no motion
// - unit select picks steps or rotations
// - ramp up/down enables, top bits read zero
// - ramp factor is two to field power
// - width changes by range minimum times factor
// - ramps start and end at range maximum
// - acceleration shortens width down to target
// - deceleration lengthens width up to maximum
// - width is prescaler and value plus one
// - direction selects forward or reverse targets
// - interrupts held until acceleration finishes
// - stop: hard, else decelerate, else immediate
`timescale 1ns/1ps
module stepper_motion_profile (
   // clock and reset
   input  wire logic                                  mclk_i,
   input  wire logic                                  rst_i,
   // register port
   input  wire logic [7:0]                            reg_addr_i,
   input  wire logic                                  reg_wr_i,
   input  wire logic [7:0]                            reg_wdata_i,
   output logic [7:0]                                 reg_rdata_o,
   // motor control
   input  wire logic                                  start_i,
   input  wire logic                                  stop_i,
   input  wire stepper_motion_pkg::motor_control_t    mctl_i,
   input  wire logic [15:0]                           fwd_step_target_i,
   input  wire logic [15:0]                           steps_per_rot_i,
   input  wire stepper_motion_pkg::pulse_width_t      fwd_width_i,
   input  wire stepper_motion_pkg::pulse_width_t      rev_width_i,
   // interrupt action setup
   input  wire stepper_motion_pkg::interrupt_setup_t  int_setup_i,
   input  wire logic [1:0]                            sensor_event_i,
   // status
   output logic                                       running_o,
   output logic                                       ramping_o,
   output logic                                       done_o,
   output logic                                       step_o,
   output logic [stepper_motion_pkg::WIDTH_W-1:0]     cur_width_o
);
   import stepper_motion_pkg::*;

   localparam logic [3:0] FIRST_IDX = 4'(REV_STEP_LO_ADDR - REV_STEP_LO_ADDR);
   localparam logic [3:0] RAMP_IDX  = 4'(RAMP_CTRL_ADDR - REV_STEP_LO_ADDR);

   // ==========================================================
   // register file
   logic [7:0]    regs_r [REG_COUNT];
   logic [3:0]    idx_w;
   logic          hit_w;
   logic [7:0]    rdata_r;

   assign hit_w = (reg_addr_i >= REV_STEP_LO_ADDR) && (reg_addr_i <= RAMP_CTRL_ADDR);
   assign idx_w = 4'(reg_addr_i - REV_STEP_LO_ADDR);

   for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
      localparam logic [7:0] MASK = (4'(g) == RAMP_IDX) ? RAMP_CTRL_WMASK : FULL_WMASK;
      always_ff @(posedge mclk_i) begin
         if (rst_i) begin
            regs_r[g] <= REG_RESET;
         end else if (reg_wr_i && hit_w && idx_w == 4'(g)) begin
            regs_r[g] <= reg_wdata_i & MASK;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rdata_r <= REG_RESET;
      end else if (hit_w) begin
         rdata_r <= regs_r[idx_w];
      end else begin
         rdata_r <= REG_RESET;
      end
   end

   assign reg_rdata_o = rdata_r;

   // ==========================================================
   // register fields
   logic [15:0] rev_step_w;
   logic [15:0] fwd_rot_w;
   logic [15:0] rev_rot_w;
   logic [7:0]  od_cnt_w [2];
   logic [7:0]  ramp_w;

   assign rev_step_w  = {regs_r[FIRST_IDX + 4'h1], regs_r[FIRST_IDX]};
   assign fwd_rot_w   = {regs_r[FIRST_IDX + 4'h3], regs_r[FIRST_IDX + 4'h2]};
   assign rev_rot_w   = {regs_r[FIRST_IDX + 4'h5], regs_r[FIRST_IDX + 4'h4]};
   assign od_cnt_w[0] = regs_r[FIRST_IDX + 4'h6];
   assign od_cnt_w[1] = regs_r[FIRST_IDX + 4'h7];
   assign ramp_w      = regs_r[RAMP_IDX];

   // ==========================================================
   // run configuration, frozen at start
   run_state_t         state_r;
   run_state_t         state_nxt;
   logic               reverse_r;
   logic [2:0]         presc_r;
   logic [WIDTH_W-1:0] target_r;
   logic [WIDTH_W-1:0] inc_r;
   logic               ramp_dn_r;
   logic               hard_r;
   logic               cont_r;
   logic [1:0]         mode_r;
   pulse_width_t       start_pw_w;
   logic               start_w;

   assign start_w    = (state_r == RUN_IDLE) && start_i;
   assign start_pw_w = mctl_i.dir[0] ? rev_width_i : fwd_width_i;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         reverse_r <= 1'b0;
         presc_r   <= 3'h0;
         target_r  <= 14'h0001;
         inc_r     <= 14'h0001;
         ramp_dn_r <= 1'b0;
         hard_r    <= 1'b0;
         cont_r    <= 1'b0;
         mode_r    <= 2'b00;
      end else if (start_w) begin
         reverse_r <= mctl_i.dir[0];
         presc_r   <= start_pw_w.prescaler;
         target_r  <= {1'b0, start_pw_w.value} + 14'h0001;
         inc_r     <= 14'h0001 << ramp_w[RAMP_FACTOR_MSB:0];
         ramp_dn_r <= ramp_w[RAMP_DOWN_BIT];
         hard_r    <= mctl_i.hard_stop;
         cont_r    <= mctl_i.continuous;
         mode_r    <= mctl_i.mode;
      end
   end

   // ==========================================================
   // step width ramp
   logic [WIDTH_W-1:0] width_r;
   logic               step_w;
   logic               accel_hit_w;
   logic               decel_top_w;

   assign accel_hit_w = {1'b0, width_r} <= {1'b0, target_r} + {1'b0, inc_r};
   assign decel_top_w = {1'b0, width_r} + {1'b0, inc_r} >= {1'b0, RANGE_MAX_UNITS};

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         width_r <= RANGE_MAX_UNITS;
      end else if (start_w) begin
         width_r <= ramp_w[RAMP_UP_BIT] ? RANGE_MAX_UNITS
                                        : {1'b0, start_pw_w.value} + 14'h0001;
      end else if (step_w && state_r == RUN_ACCEL) begin
         width_r <= accel_hit_w ? target_r : width_r - inc_r;
      end else if (step_w && state_r == RUN_DECEL) begin
         width_r <= decel_top_w ? RANGE_MAX_UNITS : width_r + inc_r;
      end
   end

   step_period_timer u_timer (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .run_i       (state_r != RUN_IDLE),
      .prescaler_i (presc_r),
      .units_i     (width_r),
      .step_o      (step_w)
   );

   // ==========================================================
   // step and rotation counting
   logic [15:0] left_r;
   logic [15:0] in_rot_r;
   logic        rot_mode_r;
   logic        leg2_r;
   logic        load_w;
   logic [15:0] load_val_w;
   logic        load_rot_w;
   logic        leg2_set_w;
   logic [15:0] step_tgt_w;
   logic [15:0] rot_tgt_w;
   logic [1:0]  pend_r;
   logic [1:0]  pend_clr_w;
   logic        sel_w;
   logic        od_ok_w;
   run_state_t  stop_state_w;

   assign step_tgt_w = reverse_r ? rev_step_w : fwd_step_target_i;
   assign rot_tgt_w  = reverse_r ? rev_rot_w : fwd_rot_w;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         left_r     <= 16'h0000;
         in_rot_r   <= 16'h0000;
         rot_mode_r <= 1'b0;
      end else if (load_w) begin
         left_r     <= load_val_w;
         in_rot_r   <= 16'h0000;
         rot_mode_r <= load_rot_w;
      end else if (step_w && left_r != 16'h0000 && state_r != RUN_DECEL) begin
         if (!rot_mode_r || in_rot_r + 16'h0001 >= steps_per_rot_i) begin
            left_r   <= left_r - 16'h0001;
            in_rot_r <= 16'h0000;
         end else begin
            in_rot_r <= in_rot_r + 16'h0001;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i || start_w) begin
         leg2_r <= 1'b0;
      end else if (leg2_set_w) begin
         leg2_r <= ~leg2_r;
      end
   end

   // ==========================================================
   // sensor events, held while running
   always_ff @(posedge mclk_i) begin
      if (rst_i || state_r == RUN_IDLE) begin
         pend_r <= 2'b00;
      end else begin
         pend_r <= (pend_r & ~pend_clr_w) | sensor_event_i;
      end
   end

   assign sel_w   = ~pend_r[0];
   assign od_ok_w = int_setup_i.ctrl_en && int_setup_i.overdrive_sel[sel_w];

   // ==========================================================
   // run sequencing
   always_comb begin
      stop_state_w = RUN_IDLE;
      if (!hard_r && ramp_dn_r) begin
         stop_state_w = RUN_DECEL;
      end
   end

   always_comb begin
      state_nxt  = state_r;
      load_w     = 1'b0;
      load_val_w = 16'h0000;
      load_rot_w = 1'b0;
      leg2_set_w = 1'b0;
      pend_clr_w = 2'b00;
      unique case (state_r)
         RUN_IDLE: begin
            if (start_i) begin
               state_nxt  = ramp_w[RAMP_UP_BIT] ? RUN_ACCEL : RUN_CRUISE;
               load_w     = 1'b1;
               load_rot_w = mctl_i.mode == MODE_ROTATIONS;
               load_val_w = mctl_i.dir[0] ? (load_rot_w ? rev_rot_w : rev_step_w)
                                          : (load_rot_w ? fwd_rot_w : fwd_step_target_i);
            end
         end
         RUN_ACCEL,
         RUN_CRUISE: begin
            if (stop_i) begin
               state_nxt = stop_state_w;
            end else if (left_r == 16'h0000) begin
               if (mode_r[1] && !leg2_r) begin
                  load_w     = 1'b1;
                  load_rot_w = 1'b1;
                  load_val_w = rot_tgt_w;
                  leg2_set_w = 1'b1;
               end else if (cont_r) begin
                  load_w     = 1'b1;
                  load_rot_w = mode_r == MODE_ROTATIONS;
                  load_val_w = load_rot_w ? rot_tgt_w : step_tgt_w;
                  leg2_set_w = leg2_r;
               end else begin
                  state_nxt = RUN_IDLE;
               end
            end else if (state_r == RUN_ACCEL) begin
               if (step_w && accel_hit_w) begin
                  state_nxt = RUN_CRUISE;
               end
            end else if (pend_r != 2'b00) begin
               pend_clr_w[sel_w] = 1'b1;
               if (od_ok_w) begin
                  if (od_cnt_w[sel_w] == 8'h00) begin
                     state_nxt = RUN_IDLE;
                  end else begin
                     state_nxt  = RUN_OVERDRIVE;
                     load_w     = 1'b1;
                     load_val_w = {8'h00, od_cnt_w[sel_w]};
                     load_rot_w = int_setup_i.unit_rotation;
                  end
               end
            end
         end
         RUN_OVERDRIVE: begin
            if (stop_i) begin
               state_nxt = stop_state_w;
            end else if (left_r == 16'h0000) begin
               state_nxt = RUN_IDLE;
            end
         end
         RUN_DECEL: begin
            if (stop_i && hard_r) begin
               state_nxt = RUN_IDLE;
            end else if (step_w && decel_top_w) begin
               state_nxt = RUN_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         state_r <= RUN_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ==========================================================
   // status outputs
   logic running_r;
   logic ramping_r;
   logic done_r;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         running_r <= 1'b0;
         ramping_r <= 1'b0;
         done_r    <= 1'b0;
      end else begin
         running_r <= state_nxt != RUN_IDLE;
         ramping_r <= (state_nxt == RUN_ACCEL) || (state_nxt == RUN_DECEL);
         done_r    <= (state_r != RUN_IDLE) && (state_nxt == RUN_IDLE);
      end
   end

   assign running_o   = running_r;
   assign ramping_o   = ramping_r;
   assign done_o      = done_r;
   assign step_o      = step_w;
   assign cur_width_o = width_r;
endmodule

// [test/host_bus_model.sv]
// host side model: byte register writes and reads
`timescale 1ns/1ps
module host_bus_model (
   // clock
   input  wire logic       mclk_i,
   // register port
   input  wire logic [7:0] reg_rdata_i,
   output logic [7:0]      reg_addr_o,
   output logic            reg_wr_o,
   output logic [7:0]      reg_wdata_o
);
   import stepper_motion_pkg::*;
   initial begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_wdata_o = 8'h00;
   end
   // ==========================================================
   // access tasks, driven at the falling edge
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      reg_addr_o = a;
      reg_wdata_o = (a == RAMP_CTRL_ADDR && d[3:0] > 4'hd) ? {d[7:4], 4'hd} : d;
      reg_wr_o = 1'b1;
      @(negedge mclk_i);
      reg_wr_o = 1'b0;
      reg_wdata_o = ~reg_wdata_o;
   endtask
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk_i);
      reg_addr_o = a;
      @(negedge mclk_i);
      d = reg_rdata_i;
   endtask
endmodule

// [test/stepper_motion_profile_assertions.sv]
// concurrent checks on the motion profile ports
`timescale 1ns/1ps
module stepper_motion_profile_checker (
   // clock and reset
   input wire logic                                 mclk_i,
   input wire logic                                 rst_i,
   // register port
   input wire logic [7:0]                           reg_addr_i,
   input wire logic                                 reg_wr_i,
   input wire logic [7:0]                           reg_wdata_i,
   input wire logic [7:0]                           reg_rdata_o,
   // motor control
   input wire logic                                 start_i,
   input wire logic                                 stop_i,
   input wire stepper_motion_pkg::motor_control_t   mctl_i,
   input wire stepper_motion_pkg::pulse_width_t     fwd_width_i,
   input wire stepper_motion_pkg::pulse_width_t     rev_width_i,
   // status
   input wire logic                                 running_o,
   input wire logic                                 ramping_o,
   input wire logic [stepper_motion_pkg::WIDTH_W-1:0] cur_width_o
);
   import stepper_motion_pkg::*;
   logic [7:0]         ctl_r;
   logic [WIDTH_W-1:0] prev_r;
   logic [WIDTH_W-1:0] tgt;
   logic [WIDTH_W-1:0] dif;
   // shadow of the ramp control register
   always_ff @(posedge mclk_i) begin
      if (rst_i)
         ctl_r <= 8'h00;
      else if (reg_wr_i && reg_addr_i == RAMP_CTRL_ADDR)
         ctl_r <= reg_wdata_i;
   end
   always_ff @(posedge mclk_i) begin
      prev_r <= cur_width_o;
   end
   assign tgt = (mctl_i.dir[0] ? {1'b0, rev_width_i.value} : {1'b0, fwd_width_i.value}) + 14'h0001;
   assign dif = (cur_width_o > prev_r) ? cur_width_o - prev_r : prev_r - cur_width_o;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   // ==========================================================
   // assertions
   a_ctrl_top_zero: assert property (reg_addr_i == RAMP_CTRL_ADDR |=> reg_rdata_o[7:6] == 2'b00)
      else $error("ramp control top bits not zero");
   a_write_readback: assert property (reg_wr_i && reg_addr_i >= REV_STEP_LO_ADDR && reg_addr_i <= OVERDRIVE1_ADDR
      ##1 reg_addr_i == $past(reg_addr_i) |=> reg_rdata_o == $past(reg_wdata_i, 2))
      else $error("written byte not read back");
   a_hard_stop: assert property (running_o && stop_i && mctl_i.hard_stop |-> ##[1:3] !running_o)
      else $error("hard stop did not halt");
   a_plain_stop: assert property (running_o && stop_i && !mctl_i.hard_stop && !ctl_r[RAMP_DOWN_BIT]
      |-> ##[1:3] !running_o)
      else $error("stop without ramp down did not halt");
   a_decel_entry: assert property (running_o && !ramping_o && stop_i && !mctl_i.hard_stop && ctl_r[RAMP_DOWN_BIT]
      |-> ##[1:3] (ramping_o && running_o))
      else $error("stop did not start ramp down");
   a_ramp_start: assert property (start_i && !running_o && ctl_r[RAMP_UP_BIT]
      |-> ##[1:3] (ramping_o && cur_width_o == RANGE_MAX_UNITS))
      else $error("ramp up not at range maximum");
   a_cruise_width: assert property (start_i && !running_o && !ctl_r[RAMP_UP_BIT]
      |-> ##[1:3] (running_o && cur_width_o == tgt))
      else $error("run width not value plus one");
   a_width_floor: assert property (running_o |-> cur_width_o >= tgt && cur_width_o <= RANGE_MAX_UNITS)
      else $error("width outside target and maximum");
   a_ramp_step: assert property (ramping_o && $past(ramping_o) && cur_width_o != prev_r
      |-> cur_width_o == RANGE_MAX_UNITS || cur_width_o == tgt || dif == (14'h0001 << ctl_r[3:0]))
      else $error("ramp width step wrong");
endmodule
bind stepper_motion_profile stepper_motion_profile_checker i_checker (
   .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .start_i(start_i), .stop_i(stop_i),
   .mctl_i(mctl_i), .fwd_width_i(fwd_width_i), .rev_width_i(rev_width_i),
   .running_o(running_o), .ramping_o(ramping_o), .cur_width_o(cur_width_o)
);

// [test/tb.sv]
// self-checking bench for the motion profile unit
`timescale 1ns/1ps
module tb;
   import stepper_motion_pkg::*;
   logic               mclk_i, rst_i, reg_wr_i, start_i, stop_i, running_o, ramping_o, done_o, step_o;
   logic [7:0]         reg_addr_i, reg_wdata_i, reg_rdata_o, d, a;
   logic [15:0]        fwd_step_target_i, steps_per_rot_i;
   logic [1:0]         sensor_event_i;
   logic [WIDTH_W-1:0] cur_width_o;
   motor_control_t     mctl_i;
   pulse_width_t       fwd_width_i, rev_width_i;
   interrupt_setup_t   int_setup_i;
   int                 n_fail, tests_run, n_steps, k;
   logic [3:0]         od_setup [6] = '{4'h0, 4'hc, 4'he, 4'he, 4'hf, 4'he};
   logic [1:0]         od_event [6] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h1};
   int                 od_steps [6] = '{10, 10, 6, 5, 7, 3};
   host_bus_model host (.mclk_i(mclk_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
      .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i));
   stepper_motion_profile i_stepper_motion_profile (.mclk_i(mclk_i), .rst_i(rst_i),
      .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .start_i(start_i), .stop_i(stop_i), .mctl_i(mctl_i), .fwd_step_target_i(fwd_step_target_i),
      .steps_per_rot_i(steps_per_rot_i), .fwd_width_i(fwd_width_i), .rev_width_i(rev_width_i),
      .int_setup_i(int_setup_i), .sensor_event_i(sensor_event_i), .running_o(running_o),
      .ramping_o(ramping_o), .done_o(done_o), .step_o(step_o), .cur_width_o(cur_width_o));
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      if (step_o === 1'b1)
         n_steps <= n_steps + 1;
   end
   // ==========================================================
   // helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic go();
      @(negedge mclk_i);
      start_i = 1'b1;
      @(negedge mclk_i);
      start_i = 1'b0;
   endtask
   task automatic halt();
      @(negedge mclk_i);
      stop_i = 1'b1;
      @(negedge mclk_i);
      stop_i = 1'b0;
      repeat (3) @(negedge mclk_i);
   endtask
   // runs to completion, firing one sensor event after ev_at steps
   task automatic run(input int ev_at, input logic [1:0] ev, input int exp);
      int i;
      bit sent;
      n_steps = 0;
      sent = 1'b0;
      go();
      for (i = 0; i < 20000 && done_o !== 1'b1; i++) begin
         @(negedge mclk_i);
         sensor_event_i = 2'h0;
         if (!sent && n_steps == ev_at && ev != 2'h0) begin
            sensor_event_i = ev;
            sent = 1'b1;
         end
      end
      check({done_o, n_steps[30:0]}, {1'b1, exp[30:0]});
   endtask
   task automatic wait_step();
      int i;
      for (i = 0; i < 2000 && step_o !== 1'b1; i++) @(negedge mclk_i);
      repeat (4) @(negedge mclk_i);
   endtask
   task automatic mid_reset();
      @(negedge mclk_i);
      rst_i = 1'b1;
      repeat (2) @(negedge mclk_i);
      rst_i = 1'b0;
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge mclk_i);
      n_fail++;
      wrap_up();
   end
   // ==========================================================
   // scenarios
   initial begin
      rst_i = 1'b1;
      start_i = 1'b0;
      stop_i = 1'b0;
      mctl_i = '0;
      fwd_step_target_i = 16'h000a;
      steps_per_rot_i = 16'h0002;
      fwd_width_i = '0;
      rev_width_i = '0;
      int_setup_i = '0;
      sensor_event_i = 2'h0;
      n_fail = 0;
      tests_run = 0;
      n_steps = 0;
      repeat (8) @(negedge mclk_i);
      rst_i = 1'b0;
      for (a = 8'h1c; a != 8'h26; a++) begin
         host.read_reg(a, d);
         check(d, 8'h00);
      end
      for (a = 8'h1c; a != 8'h25; a++) host.write_reg(a, a ^ 8'ha5);
      for (a = 8'h1c; a != 8'h25; a++) begin
         host.read_reg(a, d);
         check(d, (a == 8'h24) ? 8'h01 : a ^ 8'ha5);
      end
      host.write_reg(RAMP_CTRL_ADDR, 8'h00);
      run(0, 2'h0, 10);
      host.write_reg(REV_STEP_LO_ADDR, 8'h03);
      host.write_reg(REV_STEP_HI_ADDR, 8'h00);
      host.write_reg(FWD_ROT_LO_ADDR, 8'h03);
      host.write_reg(FWD_ROT_HI_ADDR, 8'h00);
      host.write_reg(REV_ROT_LO_ADDR, 8'h02);
      host.write_reg(REV_ROT_HI_ADDR, 8'h00);
      mctl_i.dir = 2'b01;
      rev_width_i.value = 13'h0001;
      run(0, 2'h0, 3);
      mctl_i.mode = MODE_ROTATIONS;
      run(0, 2'h0, 4);
      mctl_i.dir = 2'b00;
      run(0, 2'h0, 6);
      mctl_i.mode = 2'b10;
      run(0, 2'h0, 16);
      mctl_i.mode = 2'b00;
      mctl_i.continuous = 1'b1;
      go();
      repeat (12) wait_step();
      check(running_o, 1'b1);
      halt();
      check(running_o, 1'b0);
      mctl_i = '0;
      host.write_reg(OVERDRIVE0_ADDR, 8'h03);
      host.write_reg(OVERDRIVE1_ADDR, 8'h02);
      for (k = 0; k < 6; k++) begin
         if (k == 5)
            host.write_reg(OVERDRIVE0_ADDR, 8'h00);
         int_setup_i = od_setup[k];
         run(3, od_event[k], od_steps[k]);
      end
      fwd_step_target_i = 16'hffff;
      host.write_reg(RAMP_CTRL_ADDR, 8'h30);
      mctl_i.hard_stop = 1'b1;
      go();
      repeat (3) @(negedge mclk_i);
      check(cur_width_o, 14'h2000);
      halt();
      check(running_o, 1'b0);
      mctl_i.hard_stop = 1'b0;
      host.write_reg(RAMP_CTRL_ADDR, 8'h20);
      go();
      halt();
      check(running_o, 1'b0);
      host.write_reg(RAMP_CTRL_ADDR, 8'h30);
      go();
      sensor_event_i = 2'h1;
      @(negedge mclk_i);
      sensor_event_i = 2'h0;
      repeat (4) @(negedge mclk_i);
      check(running_o, 1'b1);
      halt();
      check(ramping_o, 1'b1);
      mid_reset();
      host.write_reg(RAMP_CTRL_ADDR, 8'h12);
      go();
      wait_step();
      wait_step();
      halt();
      wait_step();
      check(cur_width_o, 14'h0005);
      wait_step();
      check(cur_width_o, 14'h0009);
      mid_reset();
      host.read_reg(OVERDRIVE1_ADDR, d);
      check(d, 8'h00);
      wrap_up();
   end
endmodule
